// ==== shared/isf_pkg.sv ====
// Constants, modes and state records for the inertial sample buffer
package isf_pkg;
    // Register offsets on the host register port
    localparam logic [7:0] ISF_CTRL_ADDR = 8'h13;
    localparam logic [7:0] ISF_DATA_ADDR = 8'h14;
    localparam logic [7:0] ISF_STAT_ADDR = 8'h15;
    // Control field positions and reset value
    localparam int ISF_RDMODE_BIT = 7;
    localparam int ISF_WTM_LSB = 4;
    localparam int ISF_SIZE_LSB = 2;
    localparam int ISF_MODE_LSB = 0;
    localparam logic [7:0] ISF_CTRL_RST = 8'h00;
    localparam logic [7:0] ISF_CTRL_WMASK = 8'hbf;
    // Status field positions and reset value
    localparam int ISF_ST_WTM = 6;
    localparam int ISF_ST_OVF = 5;
    localparam int ISF_ST_NE = 4;
    localparam logic [7:0] ISF_STAT_RST = 8'h00;
    // Store geometry: bytes, bytes per axis triplet, triplet slots
    localparam int ISF_BYTES = 1536;
    localparam int ISF_TRIP_BYTES = 6;
    localparam int ISF_SLOTS = ISF_BYTES / ISF_TRIP_BYTES;
    localparam int ISF_BASE_SAMPLES = 16;
    localparam logic [2:0] ISF_LAST_BYTE = 3'h5;
    localparam logic [3:0] ISF_FSS_MAX = 4'hf;
    // Operating modes
    typedef enum logic [1:0] {
        ISF_BYPASS = 2'b00,
        ISF_FIFO = 2'b01,
        ISF_STREAM = 2'b10,
        ISF_UNUSED = 2'b11
    } isf_mode_t;
    // Core domain state
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] wr_ptr;
        logic [7:0] rd_ptr;
        logic [8:0] count;
        logic [2:0] byte_idx;
        logic ovf;
        logic wtm;
        logic [7:0] resp;
        logic ack_tgl;
        logic req_s1;
        logic req_s2;
        logic req_prev;
        logic [47:0] bypass;
    } isf_core_t;
    // Host link domain state
    typedef struct packed {
        logic busy;
        logic req_tgl;
        logic we;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic ack_s1;
        logic ack_s2;
        logic ack_prev;
        logic [7:0] rdata;
        logic ack;
    } isf_host_t;
endpackage

// ==== logic/isf_top.sv ====
// Inertial sample buffer: triplet store, modes, watermark, host register port
`timescale 1ns/1ps

// Contract
// R1 - 1536-byte store keeps arrival order
// R2 - Data read pops oldest byte
// R3 - Host drains whole 6/12/18-byte groups
// R4 - Host finishes burst before next sample
// R5 - All active sensors share one rate
// R6 - Capture only with accel or gyro enabled
// R7 - Watermark reached raises pin and flag
// R8 - Host command, read mode, drain, clear
// R9 - Bytes leave X, Y, Z low then high
// R10 - Third sensor adds magnetometer bytes in group; code keeps 6-byte triplets, mag_en_in only scales capacity and level step
// R11 - Bypass keeps store empty, latest sample only
// R12 - Mode code selects bypass, stop, stream
// R13 - Stop mode drops when full, resumes empty
// R14 - Stream mode overwrites oldest when full
// R15 - Watermark code selects quarter fractions
// R16 - Size code sets capacity per sensor
// R17 - Read-mode bit gates data register reads
// R18 - Status bits layout, reset to zero
// R19 - Coarse fill level in samples per step
// R20 - Overflow on drop, cleared when drained
module isf_top import isf_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic host_clk_in,
    input wire logic host_req_in,
    input wire logic host_we_in,
    input wire logic [7:0] host_addr_in,
    input wire logic [7:0] host_wdata_in,
    output logic host_busy_out,
    output logic host_ack_out,
    output logic [7:0] host_rdata_out,
    input wire logic acc_en_in,
    input wire logic gyr_en_in,
    input wire logic mag_en_in,
    input wire logic trip_valid_in,
    input wire logic [47:0] trip_data_in,
    output logic second_interrupt_pin_out,
    output logic [47:0] bypass_sample_out
);
    // Capacity in triplets, clipped to the physical store
    function automatic logic [8:0] cap_f(input logic [1:0] sz, input logic [1:0] ns);
        logic [10:0] t;
        t = 11'(ISF_BASE_SAMPLES << sz) * 11'(ns);
        cap_f = (t > 11'(ISF_SLOTS)) ? 9'(ISF_SLOTS) : t[8:0];
    endfunction

    // Watermark threshold as a quarter multiple of capacity
    function automatic logic [8:0] thr_f(input logic [8:0] cap, input logic [1:0] wc);
        logic [10:0] t;
        t = 11'(cap) * 11'(wc);
        thr_f = t[10:2];
    endfunction

    // Coarse level: samples per step doubles with size, and once more for several sensors
    function automatic logic [3:0] fss_f(input logic [8:0] cnt, input logic [1:0] sz, input logic [1:0] ns);
        logic [8:0] lvl;
        logic [2:0] sh;
        sh = 3'(sz) + 3'h1 + ((ns > 2'h1) ? 3'h1 : 3'h0);
        lvl = cnt >> sh;
        fss_f = (lvl > 9'(ISF_FSS_MAX)) ? ISF_FSS_MAX : lvl[3:0];
    endfunction

    isf_core_t c_q; // Core domain state
    isf_core_t c_d; // Core next state
    isf_host_t h_q; // Link domain state
    isf_host_t h_d; // Link next state
    logic [47:0] mem [0:ISF_SLOTS-1]; // Triplet store, six bytes per slot
    logic mem_we; // Store write strobe
    logic [7:0] mem_wa; // Store write slot
    logic [47:0] head_word; // Oldest triplet
    logic [7:0] head_byte; // Oldest byte
    logic [1:0] nsens; // Enabled sensor count
    logic [8:0] cap; // Capacity in triplets
    logic [8:0] thr; // Watermark threshold
    isf_mode_t mode; // Decoded operating mode
    logic rd_mode; // Data reads allowed
    logic op; // Host access arrives in core domain
    logic pop; // Data register read that removes a byte
    logic push; // Triplet offered while capture is allowed
    logic [7:0] status; // Status register image

    // Field decode shared by next-state logic and checks
    always_comb begin
        nsens = 2'(acc_en_in) + 2'(gyr_en_in) + 2'(mag_en_in);
        cap = cap_f(c_q.ctrl[ISF_SIZE_LSB +: 2], nsens); // see R16
        thr = thr_f(cap, c_q.ctrl[ISF_WTM_LSB +: 2]); // see R15
        mode = isf_mode_t'(c_q.ctrl[ISF_MODE_LSB +: 2]); // see R12
        rd_mode = c_q.ctrl[ISF_RDMODE_BIT];
        head_word = mem[c_q.rd_ptr];
        head_byte = head_word[{c_q.byte_idx, 3'b000} +: 8]; // see R9
        op = c_q.req_s2 != c_q.req_prev;
        pop = op && !h_q.we && (h_q.addr == ISF_DATA_ADDR) && rd_mode && (c_q.count != 9'h000); // see R17
        push = trip_valid_in && (acc_en_in || gyr_en_in); // see R6
        status = ISF_STAT_RST;
        status[ISF_ST_WTM] = c_q.wtm; // see R18
        status[ISF_ST_OVF] = c_q.ovf;
        status[ISF_ST_NE] = c_q.count != 9'h000;
        status[3:0] = fss_f(c_q.count, c_q.ctrl[ISF_SIZE_LSB +: 2], nsens); // see R19
    end

    // Core next state: register access, pop, capture, flags
    always_comb begin
        c_d = c_q;
        mem_we = 1'b0;
        mem_wa = c_q.wr_ptr;
        // Request toggle synchroniser from the link domain
        c_d.req_s1 = h_q.req_tgl;
        c_d.req_s2 = c_q.req_s1;
        c_d.req_prev = c_q.req_s2;
        // Register access, answer held until the next access
        if (op) begin
            c_d.ack_tgl = ~c_q.ack_tgl;
            c_d.resp = 8'h00;
            if (h_q.we) begin
                if (h_q.addr == ISF_CTRL_ADDR) begin
                    c_d.ctrl = h_q.wdata & ISF_CTRL_WMASK;
                end
            end else if (h_q.addr == ISF_CTRL_ADDR) begin
                c_d.resp = c_q.ctrl;
            end else if (h_q.addr == ISF_DATA_ADDR) begin
                c_d.resp = pop ? head_byte : 8'h00; // see R17
            end else if (h_q.addr == ISF_STAT_ADDR) begin
                c_d.resp = status;
            end
        end
        // Oldest byte leaves; slot frees after its sixth byte
        if (pop) begin
            if (c_q.byte_idx == ISF_LAST_BYTE) begin // see R2
                c_d.byte_idx = 3'h0;
                c_d.rd_ptr = c_q.rd_ptr + 8'h01;
                c_d.count = c_q.count - 9'h001;
                if (c_q.count == 9'h001) begin
                    c_d.ovf = 1'b0; // see R20
                end
            end else begin
                c_d.byte_idx = c_q.byte_idx + 3'h1; // see R9
            end
        end
        // Capture per mode
        if (mode == ISF_BYPASS || mode == ISF_UNUSED) begin
            // Store held empty, newest sample overwrites the last
            c_d.count = 9'h000; // see R11
            c_d.wr_ptr = 8'h00;
            c_d.rd_ptr = 8'h00;
            c_d.byte_idx = 3'h0;
            c_d.ovf = 1'b0;
            if (push) begin
                c_d.bypass = trip_data_in; // see R11
            end
        end else if (push) begin
            if (c_d.count < cap && !(mode == ISF_FIFO && c_d.ovf)) begin
                // Room: append in arrival order
                mem_we = 1'b1; // see R1, R10
                c_d.wr_ptr = c_q.wr_ptr + 8'h01;
                c_d.count = c_d.count + 9'h001;
            end else if (mode == ISF_STREAM) begin
                // Full ring: newest replaces oldest
                mem_we = 1'b1; // see R14
                c_d.wr_ptr = c_q.wr_ptr + 8'h01;
                c_d.rd_ptr = c_d.rd_ptr + 8'h01;
                c_d.byte_idx = 3'h0;
                c_d.ovf = 1'b1; // see R20
            end else begin
                // Stop mode: drop and hold until drained
                c_d.ovf = 1'b1; // see R13, R20
            end
        end
        // Watermark level, code zero disables
        c_d.wtm = (c_q.ctrl[ISF_WTM_LSB +: 2] != 2'b00) && (c_d.count >= thr) && (c_d.count != 9'h000); // see R7
    end

    // Core state register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            c_q <= '0;
        end else begin
            c_q <= c_d;
        end
    end

    // Triplet store, no reset
    always_ff @(posedge clk_in) begin
        if (mem_we) begin
            mem[mem_wa] <= trip_data_in;
        end
    end

    // Link next state: take a request, wait for the answer toggle
    always_comb begin
        h_d = h_q;
        h_d.ack = 1'b0;
        // Answer toggle synchroniser from the core domain
        h_d.ack_s1 = c_q.ack_tgl;
        h_d.ack_s2 = h_q.ack_s1;
        h_d.ack_prev = h_q.ack_s2;
        if (h_q.ack_s2 != h_q.ack_prev) begin
            // Answer is stable in the core until the next request
            h_d.busy = 1'b0;
            h_d.ack = 1'b1;
            h_d.rdata = c_q.resp;
        end else if (host_req_in && !h_q.busy && !h_q.ack) begin
            // Latch the access and hand it over by toggle
            // No take while the answer pulse stands: the host still holds its last request then
            h_d.busy = 1'b1;
            h_d.req_tgl = ~h_q.req_tgl;
            h_d.we = host_we_in;
            h_d.addr = host_addr_in;
            h_d.wdata = host_wdata_in;
        end
    end

    // Link state register
    always_ff @(posedge host_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            h_q <= '0;
        end else begin
            h_q <= h_d;
        end
    end

    // Outputs straight from flip-flops
    assign host_busy_out = h_q.busy;
    assign host_ack_out = h_q.ack;
    assign host_rdata_out = h_q.rdata;
    assign second_interrupt_pin_out = c_q.wtm;
    assign bypass_sample_out = c_q.bypass;

    // Checks in the core domain
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    a_pop_level_drop: assert property (pop && c_q.byte_idx == ISF_LAST_BYTE && !push
        |=> c_q.count == $past(c_q.count) - 9'h001) else $error("Level did not drop after sixth byte"); // see R2
    a_byte_sequence: assert property (pop && c_q.byte_idx != ISF_LAST_BYTE && !push && mode != ISF_BYPASS
        |=> c_q.byte_idx == $past(c_q.byte_idx) + 3'h1) else $error("Byte index did not advance"); // see R9
    a_bypass_empty: assert property (mode == ISF_BYPASS |=> c_q.count == 9'h000 && !c_q.wtm)
        else $error("Store not empty in bypass"); // see R11
    a_disabled_no_take: assert property (trip_valid_in && !acc_en_in && !gyr_en_in && !pop
        |=> $stable(c_q.count)) else $error("Sample taken with sensors off"); // see R6
    a_wtm_pin: assert property (c_q.ctrl[ISF_WTM_LSB +: 2] != 2'b00 && c_q.count >= thr && c_q.count != 9'h000
        && $stable(c_q.count) && $stable(c_q.ctrl) |-> second_interrupt_pin_out && status[ISF_ST_WTM])
        else $error("Watermark not raised"); // see R7
    a_stop_drop: assert property (push && mode == ISF_FIFO && c_q.count >= cap && !pop && $stable(c_q.ctrl)
        |=> c_q.ovf && $stable(c_q.count)) else $error("Full stop mode took a sample"); // see R13
    a_stream_keep: assert property (push && mode == ISF_STREAM && c_q.count == cap && !pop && $stable(c_q.ctrl)
        |=> c_q.count == $past(c_q.count) && c_q.ovf) else $error("Stream overwrite wrong"); // see R14
    a_read_gate: assert property (op && !h_q.we && h_q.addr == ISF_DATA_ADDR && !rd_mode && mode != ISF_BYPASS
        && !push |=> $stable(c_q.rd_ptr) && $stable(c_q.byte_idx) && c_q.resp == 8'h00)
        else $error("Read popped with read mode off"); // see R17
    a_empty_status: assert property (c_q.count == 9'h000 |-> status[ISF_ST_NE] == 1'b0 && status[3:0] == 4'h0)
        else $error("Empty store shows a level"); // see R18, R19
    a_ack_bounded: assert property ($rose(h_q.busy) |-> ##[1:12] op)
        else $error("Access never reached the core");

    c_stream_wrap: cover property (push && mode == ISF_STREAM && c_q.count == cap);
    c_wtm_hit: cover property ($rose(c_q.wtm));
    c_group_drained: cover property (pop && c_q.byte_idx == ISF_LAST_BYTE && c_q.count == 9'h001);
    c_stop_resume: cover property (c_q.ovf ##1 !c_q.ovf);
endmodule

// ==== test/isf_host_model.sv ====
// Host-side model of the register request port
`timescale 1ns/1ps
module isf_host_model (
    input wire logic hclk_in,
    input wire logic ack_in,
    input wire logic [7:0] rdata_in,
    output logic req_out,
    output logic we_out,
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out
);
    // Idle port at time zero
    initial begin
        req_out = 1'b0;
        we_out = 1'b0;
        addr_out = 8'h00;
        wdata_out = 8'h00;
    end
    // One access: hold request until ack, then release
    task automatic access(input logic we, input logic [7:0] a, input logic [7:0] wd,
                          output logic [7:0] rd, output bit ok);
        ok = 1'b0;
        rd = 8'h00;
        @(posedge hclk_in);
        req_out <= 1'b1;
        we_out <= we;
        addr_out <= a;
        wdata_out <= wd;
        // Bounded wait for the answer
        for (int n = 0; n < 400 && !ok; n++) begin
            @(posedge hclk_in);
            if (ack_in === 1'b1) begin
                ok = 1'b1;
                rd = rdata_in;
            end
        end
        // Released lines show the inverse, not the old value
        req_out <= 1'b0;
        we_out <= ~we;
        addr_out <= ~a;
        wdata_out <= ~wd;
    endtask
endmodule

// ==== test/test_isf_top.sv ====
// Self-checking bench for the inertial sample buffer
`timescale 1ns/1ps
module test_isf_top import isf_pkg::*;;
    logic clk_in = 1'b0, rst_n_in = 1'b0, host_clk_in = 1'b0;
    logic acc_en = 1'b0, gyr_en = 1'b0, mag_en = 1'b0, tv = 1'b0;
    logic [47:0] td = 48'h0, byp, last_d;
    logic req, we, busy, ack, second_interrupt_pin;
    logic [7:0] addr, wdata, rdata, rd;
    logic [47:0] q[$]; // Expected store contents
    int err_count = 0, cmp_count = 0;
    int cap_e = 16, wtm_e = 1, step_e = 2; // Expected capacity, watermark code, samples per level step
    // Core clock, 100 ns
    always #50 clk_in = ~clk_in;
    // Link clock, 6 ns, offset phase
    initial begin
        #1.3;
        forever #3 host_clk_in = ~host_clk_in;
    end
    isf_top dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .host_clk_in(host_clk_in),
        .host_req_in(req), .host_we_in(we), .host_addr_in(addr), .host_wdata_in(wdata),
        .host_busy_out(busy), .host_ack_out(ack), .host_rdata_out(rdata),
        .acc_en_in(acc_en), .gyr_en_in(gyr_en), .mag_en_in(mag_en), .trip_valid_in(tv),
        .trip_data_in(td), .second_interrupt_pin_out(second_interrupt_pin), .bypass_sample_out(byp));
    isf_host_model u_host (.hclk_in(host_clk_in), .ack_in(ack), .rdata_in(rdata),
        .req_out(req), .we_out(we), .addr_out(addr), .wdata_out(wdata));
    // Compare and count
    task chk(input string nm, input logic [47:0] e, input logic [47:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Register access through the host model
    task acc(input logic w, input logic [7:0] a, input logic [7:0] wd);
        bit ok;
        u_host.access(w, a, wd, rd, ok);
        chk("ack", 1, {47'h0, ok});
        // Busy gone and the answer pulse over half a link cycle later
        @(negedge host_clk_in);
        chk("busy ack after", 48'h0, {46'h0, busy, ack});
    endtask
    // Expected status from configured capacity, watermark code and level step
    function automatic logic [7:0] exp_stat(input int cnt, input bit ovf);
        int lvl;
        lvl = cnt / step_e;
        return {1'b0, cnt >= cap_e * wtm_e / 4 && cnt != 0, ovf, cnt != 0, 4'((lvl > 15) ? 15 : lvl)};
    endfunction
    // Push n random triplets; kind 0 dropped, 1 stop mode, 2 stream mode
    task automatic push(input int n, input int kind);
        logic [47:0] d;
        for (int i = 0; i < n; i++) begin
            d = {16'($urandom()), 32'($urandom())};
            @(posedge clk_in);
            tv <= 1'b1;
            td <= d;
            last_d = d;
            if (kind == 2 && q.size() == cap_e) void'(q.pop_front());
            if (kind != 0 && q.size() < cap_e) q.push_back(d);
        end
        @(posedge clk_in);
        tv <= 1'b0;
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
    endtask
    // Drain whole triplets, oldest first, low byte before high
    task automatic drain;
        logic [47:0] t;
        while (q.size() > 0) begin
            t = q.pop_front();
            for (int b = 0; b < 6; b++) begin
                acc(1'b0, ISF_DATA_ADDR, 8'h00);
                chk("data", {40'h0, t[8*b +: 8]}, {40'h0, rd});
            end
        end
    endtask
    // Status read and compare
    task stat(input logic [7:0] e);
        acc(1'b0, ISF_STAT_ADDR, 8'h00);
        chk("status", e, rd);
    endtask
    // Verdict
    task results;
        $display("Checks %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Watchdog about four times the expected run
    initial begin
        #500us;
        err_count++;
        $display("FAIL watchdog expected done seen timeout");
        results;
    end
    // Main sequence
    initial begin
        void'($urandom(32'hc25f));
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        acc(1'b0, ISF_CTRL_ADDR, 8'h00);
        chk("ctrl reset", ISF_CTRL_RST, rd);
        stat(ISF_STAT_RST);
        acc(1'b0, 8'h20, 8'h00);
        chk("unmapped", 0, rd);
        // Bypass: latest sample only, store empty
        @(posedge clk_in) acc_en <= 1'b1;
        push(3, 0);
        chk("bypass", last_d, byp);
        stat(8'h00);
        // Stop mode, read mode on, reserved bit written
        acc(1'b1, ISF_CTRL_ADDR, 8'hd1);
        acc(1'b0, ISF_CTRL_ADDR, 8'h00);
        chk("ctrl", 8'h91, rd);
        push(3, 1);
        chk("second_interrupt_pin below", 0, second_interrupt_pin);
        push(1, 1);
        chk("second_interrupt_pin at mark", 1, second_interrupt_pin);
        stat(exp_stat(4, 0));
        push(14, 1);
        stat(exp_stat(16, 1));
        drain;
        stat(8'h00);
        acc(1'b0, ISF_DATA_ADDR, 8'h00);
        chk("empty read", 0, rd);
        push(2, 1);
        stat(exp_stat(2, 0));
        // Read mode off: data port gives nothing
        acc(1'b1, ISF_CTRL_ADDR, 8'h11);
        acc(1'b0, ISF_DATA_ADDR, 8'h00);
        chk("rd mode off", 0, rd);
        stat(exp_stat(2, 0));
        // Stream mode overwrites oldest
        acc(1'b1, ISF_CTRL_ADDR, 8'h92);
        q.delete();
        push(20, 2);
        stat(exp_stat(16, 1));
        drain;
        // No sensor: nothing captured; gyro alone captures
        @(posedge clk_in) acc_en <= 1'b0;
        push(2, 0);
        stat(8'h00);
        @(posedge clk_in) gyr_en <= 1'b1;
        push(1, 1);
        stat(exp_stat(1, 0));
        drain;
        // Three sensors at one shared rate: size 00 holds 48 triplets, mark at half
        @(posedge clk_in) begin
            acc_en <= 1'b1;
            mag_en <= 1'b1;
        end
        acc(1'b1, ISF_CTRL_ADDR, 8'ha1);
        cap_e = 48;
        wtm_e = 2;
        step_e = 4;
        push(20, 1);
        stat(exp_stat(20, 0));
        push(4, 1);
        chk("second_interrupt_pin half", 1, second_interrupt_pin);
        stat(exp_stat(24, 0));
        // Size code 01 doubles capacity, mark and level step follow
        acc(1'b1, ISF_CTRL_ADDR, 8'ha5);
        cap_e = 96;
        step_e = 8;
        stat(exp_stat(24, 0));
        chk("second_interrupt_pin size 01", 0, second_interrupt_pin);
        drain;
        // Unused mode code keeps the store empty
        acc(1'b1, ISF_CTRL_ADDR, 8'h93);
        push(1, 0);
        stat(8'h00);
        results;
    end
endmodule
